// file: hdl/sps_cfg.svh
/*
 * Constants of the switchgear position supervisor: widths, reset values and position codes.
 * Assumes it is included by its bare name from the package and the supervisor module.
 */
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define SPS_TMR_W        24

// ----------------------------------------------------------------------------
// Position codes
// ----------------------------------------------------------------------------
`define SPS_POS_INDETERM 2'h0
`define SPS_POS_OPEN     2'h1
`define SPS_POS_CLOSED   2'h2
`define SPS_POS_DISTURB  2'h3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SPS_TMR_RST      24'h000000
`define SPS_CODE_RST     2'h0
`define SPS_BIT_RST      1'b0

`endif

// file: hdl/sps_pkg.sv
/*
 * Types shared by the switchgear position supervisor and its contact synchroniser.
 * Assumes sps_cfg.svh is on the include path.
 */
`include "sps_cfg.svh"

package sps_pkg;

    typedef enum logic [1:0] {
        SPS_IDLE,
        SPS_MOVE,
        SPS_DWELL
    } sps_state_t;

    typedef struct packed {
        logic [`SPS_TMR_W-1:0] move_close;
        logic [`SPS_TMR_W-1:0] move_open;
        logic [`SPS_TMR_W-1:0] dwell;
    } sps_times_t;

    typedef struct packed {
        logic       closed;
        logic       open;
        logic       indeterm;
        logic       disturb;
        logic [1:0] code;
    } sps_pos_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sps_sync_t;

    typedef struct packed {
        sps_state_t            st;
        logic [`SPS_TMR_W-1:0] tmr;
        logic                  tgt_close;
        logic                  sup;
        logic                  disturb;
        logic                  close_rly;
        logic                  open_rly;
        logic                  prot_close_rly;
        logic                  prot_open_rly;
        sps_pos_t              pos;
        logic                  one_contact;
        logic                  change;
    } sps_ctl_t;

endpackage

// file: hdl/sps_pin_sync.sv
/*
 * Three-stage synchroniser for one auxiliary contact pin.
 * Assumes the pin is asynchronous to sys_clk; the level moves once stages two and three agree.
 */
`timescale 1ns/100ps

module sps_pin_sync
    import sps_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic pin,
    output logic      lvl
);

    sps_sync_t q;
    sps_sync_t d;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    // Stage one feeds stage two only, so a metastable sample never reaches logic.
    always_comb
    begin
        d    = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3)
        begin
            d.lvl = q.s3;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign lvl = q.lvl;

endmodule

// file: hdl/sps_supervisor.sv
/*
 * Switchgear position supervisor: validates two auxiliary contacts against close and open
 * moving timers, limits the command relay pulses and reports the validated position.
 * Assumes contact pins are asynchronous, and commands and settings come from sys_clk logic.
 */
`timescale 1ns/100ps

`include "sps_cfg.svh"

module sps_supervisor
    import sps_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       aux_closed_pin,
    input  wire logic       aux_open_pin,
    input  wire logic       closed_assigned,
    input  wire logic       open_assigned,
    input  sps_times_t      times,
    input  wire logic       cmd_close,
    input  wire logic       cmd_open,
    input  wire logic       prot_close,
    input  wire logic       prot_open,
    input  wire logic       prot_share_en,
    output logic            close_relay,
    output logic            open_relay,
    output logic            prot_close_relay,
    output logic            prot_open_relay,
    output sps_pos_t        pos,
    output logic            one_contact_flag,
    output logic            pos_change
);

    sps_ctl_t q;
    sps_ctl_t d;
    logic     aux_closed;
    logic     aux_open;

    // ------------------------------------------------------------------------
    // Contact inputs
    // ------------------------------------------------------------------------
    // Both contacts run through the filter on every clock, idle or not.
    sps_pin_sync u_sync_closed (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .pin     (aux_closed_pin),
        .lvl     (aux_closed)
    );

    sps_pin_sync u_sync_open (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .pin     (aux_open_pin),
        .lvl     (aux_open)
    );

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    // Position as the contacts alone show it; with both assigned, equal contacts give the indeterminate code.
    function automatic logic [1:0] contact_pos(
        input logic c,
        input logic o,
        input logic ca,
        input logic oa
    );
        logic [1:0] p;
        p = `SPS_POS_INDETERM;
        if (ca && oa)
        begin
            if (c && !o)
            begin
                p = `SPS_POS_CLOSED;
            end
            else if (!c && o)
            begin
                p = `SPS_POS_OPEN;
            end
        end
        else if (ca)
        begin
            p = c ? `SPS_POS_CLOSED : `SPS_POS_OPEN;
        end
        else if (oa)
        begin
            p = o ? `SPS_POS_OPEN : `SPS_POS_CLOSED;
        end
        return p;
    endfunction

    function automatic logic [1:0] target_code(input logic to_close);
        return to_close ? `SPS_POS_CLOSED : `SPS_POS_OPEN;
    endfunction

    // Timers count down to one, so a value of one marks the last tick of an interval.
    function automatic logic timer_done(input logic [`SPS_TMR_W-1:0] t);
        return (t <= `SPS_TMR_W'(1));
    endfunction

    function automatic logic [`SPS_TMR_W-1:0] timer_next(input logic [`SPS_TMR_W-1:0] t);
        return t - `SPS_TMR_W'(1);
    endfunction

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    logic       cls;
    logic       opn;
    logic [1:0] raw;
    logic       two;
    logic       start;
    logic       start_close;
    logic       reached;
    logic       timing;

    always_comb
    begin
        d           = q;
        d.change    = 1'b0;
        start       = 1'b0;
        start_close = 1'b0;
        two         = closed_assigned && open_assigned;
        // Shared relays let trips reuse the wiring of the ordinary commands.
        cls = cmd_close || (prot_close && prot_share_en);
        opn = cmd_open || (prot_open && prot_share_en);
        d.prot_close_rly = prot_close && !prot_share_en;
        d.prot_open_rly  = prot_open && !prot_share_en;
        raw     = contact_pos(aux_closed, aux_open, closed_assigned, open_assigned);
        reached = (raw == target_code(q.tgt_close));

        // Open wins over close, and an open may cut short a running close.
        unique case (q.st)
            SPS_IDLE,
            SPS_DWELL:
            begin
                if (opn)
                begin
                    start = 1'b1;
                end
                else if (cls)
                begin
                    start       = 1'b1;
                    start_close = 1'b1;
                end
                else if (q.st == SPS_DWELL)
                begin
                    if (timer_done(q.tmr))
                    begin
                        d.st      = SPS_IDLE;
                        d.tmr     = `SPS_TMR_RST;
                        // Settling here avoids one stale disturbed cycle before the final position.
                        d.disturb = q.disturb && !reached;
                    end
                    else
                    begin
                        d.tmr = timer_next(q.tmr);
                    end
                end
                else if (q.disturb && reached)
                begin
                    d.disturb = 1'b0;
                end
            end
            SPS_MOVE:
            begin
                if (opn && q.tgt_close)
                begin
                    start = 1'b1;
                end
                else if (reached)
                begin
                    // Feedback ends the pulse before the moving time runs out.
                    d.st        = SPS_IDLE;
                    d.tmr       = `SPS_TMR_RST;
                    d.close_rly = 1'b0;
                    d.open_rly  = 1'b0;
                    d.disturb   = 1'b0;
                end
                else if (timer_done(q.tmr))
                begin
                    d.close_rly = 1'b0;
                    d.open_rly  = 1'b0;
                    d.disturb   = q.sup;
                    d.st        = SPS_IDLE;
                    d.tmr       = `SPS_TMR_RST;
                    if (q.sup && !two && (times.dwell != `SPS_TMR_RST))
                    begin
                        d.st  = SPS_DWELL;
                        d.tmr = times.dwell;
                    end
                end
                else
                begin
                    d.tmr = timer_next(q.tmr);
                end
            end
            default:
            begin
                // A corrupted state code drops both relays and falls back to idle.
                d.st        = SPS_IDLE;
                d.tmr       = `SPS_TMR_RST;
                d.close_rly = 1'b0;
                d.open_rly  = 1'b0;
                d.disturb   = 1'b0;
            end
        endcase

        if (start)
        begin
            d.st        = SPS_MOVE;
            d.tgt_close = start_close;
            d.disturb   = 1'b0;
            d.close_rly = start_close;
            d.open_rly  = !start_close;
            // A single contact can only watch the direction it reports.
            d.sup = start_close ? closed_assigned : open_assigned;
            // A zero setting still gives a one-tick pulse rather than none.
            d.tmr = start_close ? times.move_close : times.move_open;
            if (d.tmr == `SPS_TMR_RST)
            begin
                d.tmr = `SPS_TMR_W'(1);
            end
        end

        // Validated position from the registered state and the filtered contacts.
        timing = ((q.st == SPS_MOVE) && q.sup) || (q.st == SPS_DWELL);
        if (!closed_assigned && !open_assigned)
        begin
            d.pos.code = `SPS_POS_DISTURB;
        end
        else if (q.st == SPS_DWELL)
        begin
            d.pos.code = `SPS_POS_INDETERM;
        end
        else if (q.disturb)
        begin
            d.pos.code = `SPS_POS_DISTURB;
        end
        else if (raw != `SPS_POS_INDETERM)
        begin
            d.pos.code = raw;
        end
        else
        begin
            d.pos.code = timing ? `SPS_POS_INDETERM : `SPS_POS_DISTURB;
        end
        // One contact cannot tell mid-travel from the old end position, so timing reads indeterminate.
        if (!two && timing)
        begin
            d.pos.code = `SPS_POS_INDETERM;
        end

        d.pos.indeterm = (d.pos.code == `SPS_POS_INDETERM);
        d.pos.open     = (d.pos.code == `SPS_POS_OPEN);
        d.pos.closed   = (d.pos.code == `SPS_POS_CLOSED);
        d.pos.disturb  = (d.pos.code == `SPS_POS_DISTURB);
        d.change       = (d.pos.code != q.pos.code);
        d.one_contact  = closed_assigned ^ open_assigned;
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q          <= '0;
            q.st       <= SPS_IDLE;
            q.pos.code <= `SPS_CODE_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign close_relay      = q.close_rly;
    assign open_relay       = q.open_rly;
    assign prot_close_relay = q.prot_close_rly;
    assign prot_open_relay  = q.prot_open_rly;
    assign pos              = q.pos;
    assign one_contact_flag = q.one_contact;
    assign pos_change       = q.change;

endmodule

// file: verif/sps_chk.sv
/* Checker: timing relations on the position supervisor ports.
   Assumes move settings stay still while a relay is out. */
`timescale 1ns/100ps
module sps_chk
    import sps_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic closed_assigned,
    input wire logic open_assigned,
    input sps_times_t times,
    input wire logic close_relay,
    input wire logic open_relay,
    input sps_pos_t  pos,
    input wire logic one_contact_flag,
    input wire logic pos_change
);
    logic [1:0]  up_q;
    logic [23:0] cc_q;
    logic [23:0] oc_q;
    wire         both = closed_assigned & open_assigned;
    wire  [23:0] cl   = (times.move_close == 24'h0) ? 24'h1 : times.move_close;
    wire  [23:0] ol   = (times.move_open == 24'h0) ? 24'h1 : times.move_open;
    // Pulse counters restart on each drop, so an overlong pulse cannot hide.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            up_q <= 2'h0;
            cc_q <= 24'h0;
            oc_q <= 24'h0;
        end
        else
        begin
            up_q <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
            cc_q <= close_relay ? cc_q + 24'h1 : 24'h0;
            oc_q <= open_relay ? oc_q + 24'h1 : 24'h0;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_cl_end; $fell(close_relay) && !open_relay && both; endsequence
    sequence s_op_end; $fell(open_relay) && both; endsequence
    property p_flags; up_q == 2'h3 |-> pos.closed == (pos.code == 2'h2)
        && pos.open == (pos.code == 2'h1) && pos.disturb == (pos.code == 2'h3)
        && pos.indeterm == (pos.code == 2'h0); endproperty
    property p_change; up_q == 2'h3 |-> pos_change == $changed(pos.code); endproperty
    property p_one; up_q != 2'h0 |-> one_contact_flag == $past(closed_assigned ^ open_assigned);
    endproperty
    property p_cl_len; close_relay |-> cc_q < cl; endproperty
    property p_op_len; open_relay |-> oc_q < ol; endproperty
    property p_cl_end; s_cl_end |-> ##1 pos.code inside {2'h2, 2'h3}; endproperty
    property p_op_end; s_op_end |-> ##1 pos.code inside {2'h1, 2'h3}; endproperty
    property p_mid; both && close_relay && $past(close_relay) |-> pos.code != 2'h3; endproperty
    property p_none; (!closed_assigned && !open_assigned)[*3] |-> pos.code == 2'h3; endproperty
    a_flags: assert property (p_flags) else $error("flags disagree with code");
    a_change: assert property (p_change) else $error("change event wrong");
    a_one: assert property (p_one) else $error("one contact flag wrong");
    a_cl_len: assert property (p_cl_len) else $error("close pulse too long");
    a_op_len: assert property (p_op_len) else $error("open pulse too long");
    a_cl_end: assert property (p_cl_end) else $error("close outcome wrong");
    a_op_end: assert property (p_op_end) else $error("open outcome wrong");
    a_mid: assert property (p_mid) else $error("disturbed while moving");
    a_none: assert property (p_none) else $error("unwired not disturbed");
endmodule

bind sps_supervisor sps_chk sps_chk_i (.sys_clk(sys_clk), .rstn(rstn),
    .closed_assigned(closed_assigned), .open_assigned(open_assigned), .times(times),
    .close_relay(close_relay), .open_relay(open_relay), .pos(pos),
    .one_contact_flag(one_contact_flag), .pos_change(pos_change));

// file: verif/sps_gear.sv
/* Behavioural switchgear: two aux contacts following the command relays.
   Assumes relays come from sys_clk logic; stuck jams the mechanism mid-travel. */
`timescale 1ns/100ps
module sps_gear
#(
    parameter int DLY = 6
)
(
    input wire logic sys_clk,
    input wire logic close_relay,
    input wire logic open_relay,
    input wire logic stuck,
    output logic     aux_closed_pin,
    output logic     aux_open_pin
);
    logic shut_q = 1'b0;
    int   run_q  = 0;
    // Mid-travel both contacts are open; the delay keeps pins off the clock edge.
    assign #5 aux_closed_pin = (run_q == 0) && shut_q;
    assign #5 aux_open_pin   = (run_q == 0) && !shut_q;
    always @(posedge sys_clk)
    begin
        if ((close_relay || open_relay) && (run_q != 0 || shut_q != close_relay))
        begin
            if (stuck)
                run_q <= 1;
            else if (run_q + 1 >= DLY)
            begin
                shut_q <= close_relay;
                run_q  <= 0;
            end
            else
                run_q <= run_q + 1;
        end
    end
endmodule

// file: verif/test_sps_supervisor.sv
/* Testbench for the position supervisor beside a behavioural switchgear.
   Assumes gear travel of 6 clocks and contact synchronisers of about 4. */
`timescale 1ns/100ps
module test_sps_supervisor
    import sps_pkg::*;
;
    logic       sys_clk, rstn, closed_assigned, open_assigned, stuck;
    logic       cmd_close, cmd_open, prot_close, prot_open, prot_share_en;
    logic       aux_closed_pin, aux_open_pin, close_relay, open_relay;
    logic       prot_close_relay, prot_open_relay, one_contact_flag, pos_change;
    sps_times_t times;
    sps_pos_t   pos;
    int         fails = 0;
    int         samples_checked = 0;
    int         n;

    sps_supervisor sps_supervisor_i (.sys_clk(sys_clk), .rstn(rstn),
        .aux_closed_pin(aux_closed_pin), .aux_open_pin(aux_open_pin),
        .closed_assigned(closed_assigned), .open_assigned(open_assigned), .times(times),
        .cmd_close(cmd_close), .cmd_open(cmd_open), .prot_close(prot_close),
        .prot_open(prot_open), .prot_share_en(prot_share_en), .close_relay(close_relay),
        .open_relay(open_relay), .prot_close_relay(prot_close_relay),
        .prot_open_relay(prot_open_relay), .pos(pos), .one_contact_flag(one_contact_flag),
        .pos_change(pos_change));
    sps_gear #(.DLY(6)) sps_gear_i (.sys_clk(sys_clk), .close_relay(close_relay),
        .open_relay(open_relay), .stuck(stuck), .aux_closed_pin(aux_closed_pin),
        .aux_open_pin(aux_open_pin));

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One-cycle command pulse, then count the cycles the relay stays out.
    task automatic drive(input logic cl, output int cnt);
        cnt = 0;
        @(negedge sys_clk);
        cmd_close = cl;
        cmd_open = !cl;
        @(negedge sys_clk);
        cmd_close = 1'b0;
        cmd_open = 1'b0;
        while ((cl ? close_relay : open_relay) && cnt < 100)
        begin
            cnt++;
            @(negedge sys_clk);
        end
        repeat (2) @(negedge sys_clk);
    endtask

    task automatic t_close_ok;
        drive(1'b1, n);
        chk(24'(n > 6 && n < 20), 24'h1);
        chk(24'(pos), 24'h22);
        $display("close with feedback done");
    endtask

    task automatic t_open_ok;
        drive(1'b0, n);
        chk(24'(n > 6 && n < 16), 24'h1);
        chk(24'(pos), 24'h11);
        $display("open with feedback done");
    endtask

    task automatic t_close_fail;
        stuck = 1'b1;
        drive(1'b1, n);
        chk(24'(n), 24'h14);
        chk(24'(pos), 24'h07);
        $display("close timeout done");
    endtask

    task automatic t_open_fail;
        drive(1'b0, n);
        chk(24'(n), 24'h10);
        chk(24'(pos), 24'h07);
        stuck = 1'b0;
        $display("open timeout done");
    endtask

    task automatic t_single;
        open_assigned = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk(24'(one_contact_flag), 24'h1);
        chk(24'(pos), 24'h11);
        drive(1'b1, n);
        chk(24'(pos), 24'h22);
        drive(1'b0, n);
        chk(24'(pos), 24'h11);
        closed_assigned = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk(24'(pos), 24'h07);
        chk(24'(one_contact_flag), 24'h0);
        closed_assigned = 1'b1;
        open_assigned = 1'b1;
        repeat (3) @(negedge sys_clk);
        $display("single contact done");
    endtask

    task automatic t_prot;
        {prot_close, prot_open} = 2'h3;
        @(negedge sys_clk);
        {prot_close, prot_open} = 2'h0;
        chk(24'({prot_close_relay, prot_open_relay, close_relay, open_relay}), 24'hC);
        prot_share_en = 1'b1;
        prot_open = 1'b1;
        @(negedge sys_clk);
        prot_open = 1'b0;
        chk(24'({prot_open_relay, open_relay}), 24'h1);
        repeat (20) @(negedge sys_clk);
        chk(24'(pos), 24'h11);
        $display("protection commands done");
    endtask

    // Closed contact only, jammed gear: moving time, then dwell as indeterminate, then disturbed.
    task automatic t_dwell;
        {open_assigned, stuck} = 2'h1;
        times.dwell = 24'h08;
        drive(1'b1, n);
        chk(24'(n), 24'h14);
        chk(24'(pos), 24'h08);
        repeat (8) @(negedge sys_clk);
        chk(24'(pos), 24'h07);
        {open_assigned, stuck} = 2'h2;
        times.dwell = 24'h00;
        drive(1'b1, n);
        chk(24'(pos), 24'h22);
        $display("single contact dwell done");
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial
    begin
        #400000;
        fails++;
        complete_run();
    end

    initial
    begin
        rstn = 1'b0;
        {closed_assigned, open_assigned, stuck} = 3'h6;
        {cmd_close, cmd_open, prot_close, prot_open, prot_share_en} = 5'h00;
        times = {24'h14, 24'h10, 24'h00};
        repeat (5) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk(24'(pos), 24'h11);
        t_close_ok();
        t_open_ok();
        t_close_fail();
        t_open_fail();
        t_open_ok();
        t_single();
        t_prot();
        t_dwell();
        complete_run();
    end
endmodule
